// file: pkg/fet_pkg.sv
// constants and types shared by the frame and exposure timing generator
package fet_pkg;

    // register byte addresses on the camera control port
    localparam logic [15:0] ADDR_PAD_DRIVE   = 16'h0012;
    localparam logic [15:0] ADDR_EXP_SOURCE  = 16'h1001;
    localparam logic [15:0] ADDR_EXP_ROWS_LO = 16'h100c;
    localparam logic [15:0] ADDR_EXP_ROWS_HI = 16'h100d;
    localparam logic [15:0] ADDR_BLANK_LO    = 16'h1012;
    localparam logic [15:0] ADDR_BLANK_HI    = 16'h1013;
    localparam logic [15:0] ADDR_LINE_LO     = 16'h102b;
    localparam logic [15:0] ADDR_LINE_HI     = 16'h102c;
    localparam logic [15:0] ADDR_DELAY_LO    = 16'h10d0;
    localparam logic [15:0] ADDR_DELAY_HI    = 16'h10d1;
    localparam logic [15:0] ADDR_STATUS      = 16'h10fe;

    // field positions
    localparam int DRIVE_CODE_LSB = 0;
    localparam int DRIVE_CODE_MSB = 1;
    localparam int SINK_SEL_BIT   = 2;
    localparam int EXP_SOURCE_BIT = 0;

    // reset values
    localparam logic [7:0]  PAD_DRIVE_RST  = 8'h00;
    localparam logic [7:0]  EXP_SOURCE_RST = 8'h01;
    localparam logic [15:0] EXP_ROWS_RST   = 16'h0010;
    localparam logic [15:0] BLANK_ROWS_RST = 16'h0016;
    localparam logic [15:0] LINE_RST       = 16'h0130;
    localparam logic [15:0] DELAY_RST      = 16'h0000;

    // timing counts in reference clock cycles or rows
    localparam logic [15:0] GLOB_CYCLES      = 16'h0788;
    localparam logic [15:0] MIN_LINE_CYCLES  = 16'h0130;
    localparam logic [15:0] BLANK_MARGIN_ROWS = 16'h000b;

    // exposure sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_EXPOSE,
        ST_GLOB,
        ST_WAIT_FRAME
    } fet_state_t;

endpackage

// file: rtl/fet_frame_exposure_timing.sv
// frame and exposure timing generator with its byte register file
`timescale 1ns/100ps
module fet_frame_exposure_timing (
    input  wire logic        clk,                  // reference clock, 40 MHz
    input  wire logic        rst_n,                // synchronous reset, active low
    input  wire logic [15:0] reg_addr,             // camera control port byte address
    input  wire logic [7:0]  reg_wdata,            // write byte
    input  wire logic        reg_wr,               // write strobe
    input  wire logic        reg_rd,               // read strobe
    output logic      [7:0]  reg_rdata,            // read byte, valid with reg_rvalid
    output logic             reg_rvalid,           // read answer pulse
    input  wire logic        run_enable,           // acquisition running
    input  wire logic        slave_mode,           // 1 slave, 0 master exposure control
    input  wire logic        two_pin_mode,         // slave readout from frame request pin
    input  wire logic [15:0] window_rows,          // rows in the readout window
    input  wire logic        exposure_request_pin, // exposure request input
    input  wire logic        frame_request_pin,    // frame request input
    output logic      [1:0]  drive_code,           // digital output drive select
    output logic             sink_high,            // control pin sink current select
    output logic             row_tick,             // one pulse per line period
    output logic             frame_start,          // frame boundary pulse
    output logic             exposure_active,      // exposure state
    output logic             readout_start,        // readout start pulse
    output logic             readout_active        // readout rows in progress
);

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0]  pad_drive_reg;
    logic [7:0]  exp_source_reg;
    logic [15:0] exp_rows_reg;
    logic [15:0] blank_rows_reg;
    logic [15:0] line_reg;
    logic [15:0] delay_reg;
    logic [7:0]  rdata_next;
    logic [7:0]  status;

    fet_pkg::fet_state_t state_reg;

    // multi-byte values: lower address holds the low byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_drive_reg  <= fet_pkg::PAD_DRIVE_RST;
            exp_source_reg <= fet_pkg::EXP_SOURCE_RST;
            exp_rows_reg   <= fet_pkg::EXP_ROWS_RST;
            blank_rows_reg <= fet_pkg::BLANK_ROWS_RST;
            line_reg       <= fet_pkg::LINE_RST;
            delay_reg      <= fet_pkg::DELAY_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                fet_pkg::ADDR_PAD_DRIVE:   pad_drive_reg        <= reg_wdata;
                fet_pkg::ADDR_EXP_SOURCE:  exp_source_reg       <= reg_wdata;
                fet_pkg::ADDR_EXP_ROWS_LO: exp_rows_reg[7:0]    <= reg_wdata;
                fet_pkg::ADDR_EXP_ROWS_HI: exp_rows_reg[15:8]   <= reg_wdata;
                fet_pkg::ADDR_BLANK_LO:    blank_rows_reg[7:0]  <= reg_wdata;
                fet_pkg::ADDR_BLANK_HI:    blank_rows_reg[15:8] <= reg_wdata;
                fet_pkg::ADDR_LINE_LO:     line_reg[7:0]        <= reg_wdata;
                fet_pkg::ADDR_LINE_HI:     line_reg[15:8]       <= reg_wdata;
                fet_pkg::ADDR_DELAY_LO:    delay_reg[7:0]       <= reg_wdata;
                fet_pkg::ADDR_DELAY_HI:    delay_reg[15:8]      <= reg_wdata;
                default: ;
            endcase
        end
    end

    // live sequencer flags for software polling
    assign status = {3'h0, readout_active, state_reg == fet_pkg::ST_WAIT_FRAME,
                     state_reg == fet_pkg::ST_GLOB, exposure_active,
                     state_reg == fet_pkg::ST_IDLE};

    // read mux, unmapped addresses read as zero
    always_comb begin
        case (reg_addr)
            fet_pkg::ADDR_PAD_DRIVE:   rdata_next = pad_drive_reg;
            fet_pkg::ADDR_EXP_SOURCE:  rdata_next = exp_source_reg;
            fet_pkg::ADDR_EXP_ROWS_LO: rdata_next = exp_rows_reg[7:0];
            fet_pkg::ADDR_EXP_ROWS_HI: rdata_next = exp_rows_reg[15:8];
            fet_pkg::ADDR_BLANK_LO:    rdata_next = blank_rows_reg[7:0];
            fet_pkg::ADDR_BLANK_HI:    rdata_next = blank_rows_reg[15:8];
            fet_pkg::ADDR_LINE_LO:     rdata_next = line_reg[7:0];
            fet_pkg::ADDR_LINE_HI:     rdata_next = line_reg[15:8];
            fet_pkg::ADDR_DELAY_LO:    rdata_next = delay_reg[7:0];
            fet_pkg::ADDR_DELAY_HI:    rdata_next = delay_reg[15:8];
            fet_pkg::ADDR_STATUS:      rdata_next = status;
            default:                   rdata_next = 8'h00;
        endcase
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    // pad controls follow the register with one flop for clean pad timing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_code <= fet_pkg::PAD_DRIVE_RST[1:0];
            sink_high  <= fet_pkg::PAD_DRIVE_RST[2];
        end else begin
            drive_code <= pad_drive_reg[fet_pkg::DRIVE_CODE_MSB:fet_pkg::DRIVE_CODE_LSB];
            sink_high  <= pad_drive_reg[fet_pkg::SINK_SEL_BIT];
        end
    end

    drive_code_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == fet_pkg::ADDR_PAD_DRIVE
        |-> ##2 drive_code == $past(reg_wdata[1:0], 2)) else $error("drive code not applied");
    sink_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == fet_pkg::ADDR_PAD_DRIVE
        |-> ##2 sink_high == $past(reg_wdata[2], 2)) else $error("sink select not applied");

    ////////////////////////////////////////////////////////////////////////////
    // active copies, taken only at a frame boundary or while stopped

    logic [15:0] exp_act;
    logic [15:0] blank_act;
    logic [15:0] line_act;
    logic [15:0] delay_act;
    logic        frame_evt;
    logic        load_act;

    // mid-frame writes would tear the row timing, so they wait for the boundary
    assign load_act = !run_enable || frame_evt;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            exp_act   <= fet_pkg::EXP_ROWS_RST;
            blank_act <= fet_pkg::BLANK_ROWS_RST;
            line_act  <= fet_pkg::LINE_RST;
            delay_act <= fet_pkg::DELAY_RST;
        end else if (load_act) begin
            exp_act   <= exp_rows_reg;
            blank_act <= blank_rows_reg;
            line_act  <= line_reg;
            delay_act <= delay_reg;
        end
    end

    frame_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        frame_evt |=> line_act == $past(line_reg) && blank_act == $past(blank_rows_reg))
        else $error("shadow values not taken at frame boundary");

    ////////////////////////////////////////////////////////////////////////////
    // row timer: every row-based quantity advances on this tick

    logic [15:0] line_count;

    fet_period_counter #(.W(16)) u_row_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .run    (run_enable),
        .period (line_act),
        .count  (line_count),
        .tick   (row_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // master frame timer: window rows plus blanking rows, columns play no part

    logic [16:0] frame_row_reg;
    logic [16:0] frame_rows;
    logic        run_q_reg;
    logic        frame_wrap;

    assign frame_rows = {1'b0, window_rows} + {1'b0, blank_act};
    assign frame_wrap = row_tick && (frame_row_reg >= frame_rows - 17'h00001);

    // slave frames begin at an accepted request, master frames at run start and at each wrap
    logic req_q_reg;
    logic frm_q_reg;
    logic req_rise;
    logic req_fall;
    logic frm_rise;

    assign req_rise  = exposure_request_pin && !req_q_reg;
    assign req_fall  = !exposure_request_pin && req_q_reg;
    assign frm_rise  = frame_request_pin && !frm_q_reg;
    assign frame_evt = run_enable && (slave_mode
                       ? (req_rise && state_reg == fet_pkg::ST_IDLE)
                       : (!run_q_reg || frame_wrap));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_row_reg <= 17'h00000;
            run_q_reg     <= 1'b0;
            frame_start   <= 1'b0;
        end else begin
            run_q_reg   <= run_enable;
            frame_start <= frame_evt;
            if (frame_evt || !run_enable) begin
                frame_row_reg <= 17'h00000;
            end else if (row_tick) begin
                frame_row_reg <= frame_row_reg + 17'h00001;
            end
        end
    end

    frame_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        run_enable && run_q_reg && !slave_mode && frame_wrap |=> frame_start)
        else $error("master frame boundary missed");

    // request pins are synchronous; one flop gives the edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_q_reg <= 1'b0;
            frm_q_reg <= 1'b0;
        end else begin
            req_q_reg <= exposure_request_pin;
            frm_q_reg <= frame_request_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // exposure sequencer

    logic [15:0] phase_rows_reg;
    logic [15:0] glob_count;
    logic        glob_tick;
    logic        timed_exp;
    logic        readout_evt;

    // master always counts; slave counts only when the source bit asks
    assign timed_exp       = !slave_mode || exp_source_reg[fet_pkg::EXP_SOURCE_BIT];
    assign exposure_active = (state_reg == fet_pkg::ST_EXPOSE);
    assign readout_evt     = run_enable && ((state_reg == fet_pkg::ST_GLOB && glob_tick
                             && !(slave_mode && two_pin_mode))
                             || (state_reg == fet_pkg::ST_WAIT_FRAME && frm_rise));

    fet_period_counter #(.W(16)) u_glob_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .run    (state_reg == fet_pkg::ST_GLOB),
        .period (fet_pkg::GLOB_CYCLES),
        .count  (glob_count),
        .tick   (glob_tick)
    );

    // a master boundary seen while still busy is skipped, not queued
    always_ff @(posedge clk) begin
        if (!rst_n || !run_enable) begin
            state_reg      <= fet_pkg::ST_IDLE;
            phase_rows_reg <= 16'h0000;
        end else begin
            case (state_reg)
                fet_pkg::ST_IDLE: begin
                    phase_rows_reg <= 16'h0000;
                    if (frame_evt) begin
                        state_reg <= slave_mode ? fet_pkg::ST_DELAY : fet_pkg::ST_EXPOSE;
                    end
                end
                fet_pkg::ST_DELAY: begin
                    if (phase_rows_reg >= delay_act) begin
                        state_reg      <= fet_pkg::ST_EXPOSE;
                        phase_rows_reg <= 16'h0000;
                    end else if (row_tick) begin
                        phase_rows_reg <= phase_rows_reg + 16'h0001;
                    end
                end
                fet_pkg::ST_EXPOSE: begin
                    if (timed_exp ? (phase_rows_reg >= exp_act) : req_fall) begin
                        state_reg      <= fet_pkg::ST_GLOB;
                        phase_rows_reg <= 16'h0000;
                    end else if (row_tick) begin
                        phase_rows_reg <= phase_rows_reg + 16'h0001;
                    end
                end
                fet_pkg::ST_GLOB: begin
                    if (glob_tick) begin
                        state_reg <= (slave_mode && two_pin_mode) ? fet_pkg::ST_WAIT_FRAME
                                                                  : fet_pkg::ST_IDLE;
                    end
                end
                fet_pkg::ST_WAIT_FRAME: begin
                    if (frm_rise) begin
                        state_reg <= fet_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= fet_pkg::ST_IDLE;
            endcase
        end
    end

    glob_length_a: assert property (@(posedge clk) disable iff (!rst_n)
        run_enable && $past(run_enable) && $past(state_reg) == fet_pkg::ST_GLOB
        && state_reg != fet_pkg::ST_GLOB |-> $past(glob_count) == fet_pkg::GLOB_CYCLES - 16'h0001)
        else $error("glob interval wrong length");
    exp_rows_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == fet_pkg::ST_EXPOSE && timed_exp && phase_rows_reg < exp_act && run_enable
        |=> state_reg == fet_pkg::ST_EXPOSE) else $error("exposure ended early");
    slave_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        run_enable && slave_mode && state_reg == fet_pkg::ST_IDLE && req_rise
        |=> state_reg == fet_pkg::ST_DELAY) else $error("exposure request not taken");
    single_pin_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        run_enable && slave_mode && !exp_source_reg[0] && state_reg == fet_pkg::ST_EXPOSE
        && req_fall |=> state_reg == fet_pkg::ST_GLOB) else $error("falling edge ignored");
    delay_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        run_enable && state_reg == fet_pkg::ST_DELAY && phase_rows_reg < delay_act
        |=> state_reg == fet_pkg::ST_DELAY) else $error("delay cut short");

    ////////////////////////////////////////////////////////////////////////////
    // readout pacing: window rows, one per row tick, may overlap next exposure

    logic [15:0] readout_rows_reg;

    always_ff @(posedge clk) begin
        if (!rst_n || !run_enable) begin
            readout_rows_reg <= 16'h0000;
            readout_active   <= 1'b0;
            readout_start    <= 1'b0;
        end else begin
            readout_start <= readout_evt;
            if (readout_evt) begin
                readout_rows_reg <= 16'h0000;
                readout_active   <= (window_rows != 16'h0000);
            end else if (readout_active && row_tick) begin
                readout_rows_reg <= readout_rows_reg + 16'h0001;
                readout_active   <= (readout_rows_reg + 16'h0001 < window_rows);
            end
        end
    end

    readout_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        run_enable && slave_mode && two_pin_mode && state_reg == fet_pkg::ST_WAIT_FRAME
        && frm_rise |=> readout_start ##1 !readout_start) else $error("readout not started");

endmodule // fet_frame_exposure_timing

// file: rtl/fet_period_counter.sv
// run-gated period counter that emits one tick per programmed period
`timescale 1ns/100ps
module fet_period_counter #(
    parameter int W = 16
) (
    input  wire logic         clk,    // reference clock
    input  wire logic         rst_n,  // synchronous reset, active low
    input  wire logic         run,    // count while high, hold at zero otherwise
    input  wire logic [W-1:0] period, // cycles per tick, zero acts as one
    output logic      [W-1:0] count,  // cycles since the last tick
    output logic              tick    // high in the last cycle of each period
);

    logic [W-1:0] last;

    // a zero period would wrap to the longest count, so it is folded onto one cycle
    assign last = (period == '0) ? '0 : period - W'(1);
    assign tick = run && (count == last);

    // restart on every tick so the period is exact whatever the value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
        end else if (!run || tick) begin
            count <= '0;
        end else begin
            count <= count + W'(1);
        end
    end

    row_count_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        run |-> count <= last) else $error("period counter beyond period");

endmodule // fet_period_counter

// file: tb/fet_host_model.sv
// host controller stand-in that drives exposure request pulses
`timescale 1ns/100ps
module fet_host_model (
    input  wire logic        clk,  // reference clock
    input  wire logic        fire, // start one request pulse
    input  wire logic [15:0] hold, // pulse width in cycles
    output logic             pin   // exposure request pin
);
    logic [15:0] left_reg;
    initial begin
        pin      = 1'b0;
        left_reg = 16'h0000;
    end
    // one pulse per fire; a fire mid-pulse is dropped so the period never shrinks
    always @(posedge clk) begin
        if (fire && !pin) begin
            pin      <= 1'b1;
            left_reg <= hold;
        end else if (left_reg > 16'h0001) begin
            left_reg <= left_reg - 16'h0001;
        end else begin
            pin      <= 1'b0;
            left_reg <= 16'h0000;
        end
    end
endmodule // fet_host_model

// file: tb/tb_top.sv
// self-checking bench for the frame and exposure timing generator
`timescale 1ns/100ps
module tb_top;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, run_enable = 0, fire = 0;
    logic        slave_mode = 0, two_pin_mode = 0, frame_request_pin = 0, exp_pin;
    logic [15:0] reg_addr = 16'h0000, window_rows = 16'h0003, hold = 16'h0010;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, d;
    logic [1:0]  drive_code;
    logic        reg_rvalid, sink_high, row_tick, frame_start;
    logic        exposure_active, readout_start, readout_active;
    int          mismatches = 0, checks = 0, cnt = 0, t0, ts, len, i;
    localparam int LINE = 320; // above the 304 floor for two lanes, spans both bytes

    always #12.5 clk = ~clk;
    always @(posedge clk) cnt <= cnt + 1;

    fet_frame_exposure_timing i_fet_frame_exposure_timing (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .run_enable(run_enable),
        .slave_mode(slave_mode), .two_pin_mode(two_pin_mode), .window_rows(window_rows),
        .exposure_request_pin(exp_pin), .frame_request_pin(frame_request_pin),
        .drive_code(drive_code), .sink_high(sink_high), .row_tick(row_tick),
        .frame_start(frame_start), .exposure_active(exposure_active),
        .readout_start(readout_start), .readout_active(readout_active));
    fet_host_model i_fet_host_model (.clk(clk), .fire(fire), .hold(hold), .pin(exp_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // the single comparison point; every mismatch is printed and counted
    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        checks++;
        if (seen !== expd) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // all tasks start and end 2 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        reg_addr = a; reg_wdata = v; reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        // an idle edge keeps back-to-back strobes apart
        cyc(1);
    endtask
    task automatic rd(input logic [15:0] a);
        reg_addr = a; reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        chk(reg_rvalid, 1'b1);
        cyc(1);
        chk(reg_rvalid, 1'b0);
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return row_tick;
            1: return frame_start;
            2: return exposure_active;
            default: return readout_start;
        endcase
    endfunction
    // bounded wait for a level on one of the timing outputs
    task automatic wt(input int w, input logic lvl, input int lim);
        for (int k = 0; k < lim; k++) begin
            cyc(1);
            if (pick(w) === lvl) return;
        end
        mismatches++;
        $display("[FAIL] %0t wait ran out", $time);
        conclude();
    endtask
    // one request pulse; returns exposure length in cycles
    task automatic pulse(input logic [15:0] h);
        hold = h; fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        wt(2, 1'b1, 2000);
        t0 = cnt;
        wt(2, 1'b0, 3000);
        len = cnt - t0;
    endtask
    // 16-bit values land low byte first
    task automatic wr16(input logic [15:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 16'h0001, v[15:8]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(51229));
        cyc(8);
        rst_n = 1'b1;
        rd(fet_pkg::ADDR_LINE_LO); chk(reg_rdata, 8'h30);
        rd(16'h2222); chk(reg_rdata, 8'h00);
        rd(fet_pkg::ADDR_BLANK_LO); chk(reg_rdata, 8'h16);
        rd(fet_pkg::ADDR_EXP_SOURCE); chk(reg_rdata[0], 1'b1);
        // every drive and sink code, random filler in the upper bits
        for (i = 0; i < 8; i++) begin
            d = {5'($urandom), 3'(i)};
            wr(fet_pkg::ADDR_PAD_DRIVE, d);
            cyc(2);
            chk(drive_code, d[1:0]);
            chk(sink_high, d[2]);
            rd(fet_pkg::ADDR_PAD_DRIVE); chk(reg_rdata[2:0], d[2:0]);
        end
        // shadows follow the bytes while stopped; frame needs glob rows plus eleven
        wr16(fet_pkg::ADDR_LINE_LO, 16'(LINE));
        wr16(fet_pkg::ADDR_BLANK_LO, 16'h0013);
        wr16(fet_pkg::ADDR_EXP_ROWS_LO, 16'h0001);
        run_enable = 1'b1;
        wt(0, 1'b1, 2 * LINE);
        t0 = cnt;
        wt(0, 1'b0, 4);
        wt(0, 1'b1, 2 * LINE);
        chk(cnt - t0, LINE);
        // master frame spacing follows line times window plus blank rows
        run_enable = 1'b0;
        cyc(2);
        run_enable = 1'b1;
        // the first boundary falls inside row zero, so time the steady frames
        wt(1, 1'b1, 50);
        wt(1, 1'b0, 4);
        wt(1, 1'b1, 30000);
        t0 = cnt;
        wt(1, 1'b0, 4);
        wt(1, 1'b1, 30000);
        chk(cnt - t0, LINE * 22);
        // slave single pin, exposure from pulse width
        run_enable = 1'b0;
        slave_mode = 1'b1;
        wr(fet_pkg::ADDR_EXP_SOURCE, 8'h00);
        wr16(fet_pkg::ADDR_DELAY_LO, 16'h0000);
        run_enable = 1'b1;
        cyc(4);
        for (i = 0; i < 3; i++) begin
            d = 8'(20 + $urandom_range(0, 180));
            pulse({8'h00, d});
            chk(len, d - 1);
            t0 = cnt;
            wt(3, 1'b1, 3000);
            chk(cnt - t0, 1928);
            cyc(8000); // request period kept above glob plus readout
        end
        // exposure by row count, then a two-row request delay
        run_enable = 1'b0;
        wr(fet_pkg::ADDR_EXP_SOURCE, 8'h01);
        wr16(fet_pkg::ADDR_EXP_ROWS_LO, 16'h0002);
        run_enable = 1'b1;
        pulse(16'h0004);
        chk(len > LINE && len <= 2 * LINE, 1'b1);
        cyc(8000);
        run_enable = 1'b0;
        wr16(fet_pkg::ADDR_DELAY_LO, 16'h0002);
        run_enable = 1'b1;
        ts = cnt;
        pulse(16'h0004);
        chk(ts + LINE + 2 < cnt - len && cnt - len <= ts + 2 * LINE + 4, 1'b1);
        // two pins: readout waits for the frame request edge
        cyc(8000);
        run_enable = 1'b0;
        two_pin_mode = 1'b1;
        wr16(fet_pkg::ADDR_DELAY_LO, 16'h0000);
        run_enable = 1'b1;
        pulse(16'h0004);
        cyc(2100);
        chk(readout_active, 1'b0);
        rd(fet_pkg::ADDR_STATUS); chk(reg_rdata, 8'h08);
        frame_request_pin = 1'b1;
        t0 = cnt;
        wt(3, 1'b1, 5);
        chk(cnt - t0 <= 3, 1'b1);
        chk(readout_active, 1'b1);
        frame_request_pin = 1'b0;
        cyc(4);
        conclude();
    end
endmodule // tb_top
